// File: bench/hpd_decode_tb.sv
// Self-checking bench for the inbound decode and ordering block
`timescale 1ns/1ns
`default_nettype none
module hpd_decode_tb;
    import hpd_pkg::*;
    localparam logic [5:0] RD = 6'h12;
    localparam logic [5:0] WR = 6'h32;
    localparam hpd_res_t FWD = '{ACT_FWD, TGT_NONE, CYC_NONE, 64'h0, 1'h0, 1'h0};
    logic ref_clk = 1'h0;
    logic rst_b = 1'h0;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'h0;
    logic avs_write = 1'h0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hf;
    logic [3:0] be = 4'hf;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic send = 1'h0;
    hpd_req_t pkt = '0;
    logic req_valid;
    hpd_req_t req;
    logic res_valid;
    hpd_res_t res;
    logic ord_valid = 1'h0;
    hpd_dom_t ord_domain = DOM_HT;
    hpd_ord_t ord_later = ORD_POSTED;
    hpd_ord_t ord_earlier = ORD_POSTED;
    hpd_pass_t ord_pass;
    int fails = 0;
    int comparisons = 0;
    logic [31:0] rd;

    always #5 ref_clk = ~ref_clk;

    hpd_ht_src hpd_ht_src_inst (.ref_clk(ref_clk), .rst_b(rst_b), .send(send), .pkt(pkt),
        .req_valid(req_valid), .req(req));
    hpd_decode hpd_decode_inst (.ref_clk(ref_clk), .rst_b(rst_b), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .req_valid(req_valid), .req(req), .res_valid(res_valid), .res(res),
        .ord_valid(ord_valid), .ord_domain(ord_domain), .ord_later(ord_later),
        .ord_earlier(ord_earlier), .ord_pass(ord_pass));

    task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Holds the request until waitrequest is sampled low, for up to 100 cycles
    task automatic bus(input logic wr, input logic [5:0] idx, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        avs_address <= {idx, 2'h0};
        avs_write <= wr;
        avs_read <= ~wr;
        avs_writedata <= d;
        avs_byteenable <= be;
        do begin
            @(posedge ref_clk);
            n++;
        end while (avs_waitrequest !== 1'h0 && n < 100);
        if (n >= 100) fails++;
        rd = avs_readdata;
        avs_write <= 1'h0;
        avs_read <= 1'h0;
    endtask

    function automatic hpd_res_t pc(hpd_cyc_t c, logic [63:0] a, logic d);
        return '{ACT_ACCEPT, TGT_PCIX, c, a, d, 1'h0};
    endfunction

    // Mask m: bit0 target, bit1 cycle and dac, bit2 address and isoc
    task automatic dec(input logic [63:0] a, input logic [5:0] f, input hpd_res_t e,
            input logic [2:0] m);
        @(posedge ref_clk);
        send <= 1'h1;
        pkt <= '{a, f[5], f[4], f[3], f[2], f[1], f[0]};
        @(posedge ref_clk);
        send <= 1'h0;
        @(posedge ref_clk);
        #1;
        chk("res_valid", 64'(res_valid), 64'h1);
        chk("action", 64'(res.action), 64'(e.action));
        if (m[0]) chk("target", 64'(res.target), 64'(e.target));
        if (m[1]) chk("cycle", 64'(res.cycle), 64'(e.cycle));
        if (m[1]) chk("dac", 64'(res.dac), 64'(e.dac));
        if (m[2]) chk("addr", res.addr, e.addr);
        if (m[2]) chk("isoc", 64'(res.isoc), 64'(e.isoc));
        // Answer stands for one cycle only
        @(posedge ref_clk);
        #1;
        chk("res_valid drop", 64'(res_valid), 64'h0);
    endtask

    task automatic t_regs();
        bus(1'h0, IDX_CTRL, 32'h0);
        chk("ctrl reset", 64'(rd), 64'h0);
        bus(1'h1, IDX_STATUS, 32'hffff_ffff);
        bus(1'h0, IDX_STATUS, 32'h0);
        chk("status", 64'(rd), 64'h0);
        bus(1'h1, 6'h14, 32'h1234_5678);
        bus(1'h0, 6'h14, 32'h0);
        chk("unmapped", 64'(rd), 64'h0);
        // Only lane 2 of this write may land
        be = 4'h4;
        bus(1'h1, IDX_MEM_BASE, 32'h1122_3344);
        be = 4'hf;
        bus(1'h0, IDX_MEM_BASE, 32'h0);
        chk("byte lane", 64'(rd), 64'h0022_0000);
    endtask

    task automatic t_mem();
        bus(1'h1, IDX_MEM_BASE, 32'h8000_0000);
        bus(1'h1, IDX_MEM_LIMIT, 32'h8000_ffff);
        bus(1'h1, IDX_PF_BASE_HI, 32'h1);
        bus(1'h1, IDX_PF_LIMIT, 32'hffff_ffff);
        bus(1'h1, IDX_PF_LIMIT_HI, 32'h1);
        bus(1'h1, IDX_CTRL, 32'h1);
        bus(1'h0, IDX_CTRL, 32'h0);
        chk("ctrl", 64'(rd), 64'h1);
        dec(64'h8000_ffff, WR, pc(CYC_MEM_WR, 64'h8000_ffff, 1'h0), 3'h7);
        dec(64'h8000_0000, RD, pc(CYC_MEM_RD, 64'h8000_0000, 1'h0), 3'h7);
        dec(64'h8001_0000, RD, FWD, 3'h0);
        dec(64'h1_0000_0040, RD, pc(CYC_MEM_RD, 64'h1_0000_0040, 1'h1), 3'h7);
        dec(64'ha_0000, RD, FWD, 3'h0);
        bus(1'h1, IDX_CTRL, 32'h5);
        dec(64'hb_ffff, WR, pc(CYC_MEM_WR, 64'hb_ffff, 1'h0), 3'h7);
        bus(1'h1, IDX_CTRL, 32'h0);
        dec(64'h8000_0000, RD, FWD, 3'h0);
    endtask

    task automatic t_io();
        bus(1'h1, IDX_IO_BASE, 32'h1000);
        bus(1'h1, IDX_IO_LIMIT, 32'h1fff);
        bus(1'h1, IDX_CTRL, 32'h2);
        dec(IO_LO | 64'h1fff, RD, pc(CYC_IO_RD, 64'h1fff, 1'h0), 3'h7);
        dec(IO_LO | 64'h2000, WR, FWD, 3'h0);
        bus(1'h1, IDX_CTRL, 32'h6);
        dec(IO_LO | 64'h3b8, WR, pc(CYC_IO_WR, 64'h3b8, 1'h0), 3'h7);
        dec(IO_LO | 64'h3bc, RD, FWD, 3'h0);
        bus(1'h1, IDX_IO_BASE, 32'h0);
        bus(1'h1, IDX_IO_LIMIT, 32'hffff);
        bus(1'h1, IDX_CTRL, 32'ha);
        dec(IO_LO | 64'h500, RD, FWD, 3'h0);
        dec(IO_LO | 64'h4ff, RD, pc(CYC_IO_RD, 64'h4ff, 1'h0), 3'h7);
    endtask

    task automatic t_cfg();
        bus(1'h1, IDX_BUS, 32'h0402);
        bus(1'h1, IDX_CTRL, 32'h500);
        dec(CFG_LO | 64'h2810, RD, '{ACT_ACCEPT, TGT_CSR, CYC_NONE, 64'h0, 1'h0, 1'h0},
            3'h1);
        dec(CFG_LO | 64'h3000, RD, FWD, 3'h0);
        dec(CFG_LO | 64'h0102_1810, RD, pc(CYC_CFG0_RD, 64'h8_1810, 1'h0), 3'h7);
        dec(CFG_LO | 64'h0104_1810, WR, pc(CYC_CFG1_WR, 64'h4_1811, 1'h0), 3'h7);
        dec(CFG_LO | 64'h0105_0000, RD, FWD, 3'h0);
        dec(INT_LO, 6'h3e, '{ACT_BOTH, TGT_INTC, CYC_EOI, 64'h0, 1'h0, 1'h0}, 3'h3);
        dec(INT_LO, RD, FWD, 3'h0);
    endtask

    task automatic t_rmp();
        bus(1'h1, IDX_RMP_BASE, 32'h4000_0000);
        bus(1'h1, IDX_RMP_LIMIT, 32'h4000_ffff);
        bus(1'h1, IDX_RMP_XLAT_HI, 32'h2);
        bus(1'h1, IDX_CTRL, 32'h30);
        dec(64'h4000_0100, 6'h31, '{ACT_FWD, TGT_NONE, CYC_NONE, 64'h2_0000_0100, 1'h0, 1'h1},
            3'h4);
        dec(64'h4000_0100, 6'h30, '{ACT_FWD, TGT_NONE, CYC_NONE, 64'h4000_0100, 1'h0, 1'h0},
            3'h4);
        // Eleven accepted and eleven forwarded packets so far
        bus(1'h0, IDX_STATUS, 32'h0);
        chk("status counts", 64'(rd), 64'h000b_000b);
    endtask

    // HT has one class each for non-posted and response: skip the write classes there
    task automatic t_ord();
        logic p;
        for (int d = 0; d < 3; d++) begin
            for (int l = 0; l < 5; l++) begin
                for (int e = 0; e < 5; e++) begin
                    if (d == 0 && (l == 2 || l == 4 || e == 2 || e == 4)) continue;
                    p = (l == 0 && e != 0) || (l >= 3 && (e == 1 || e == 2));
                    @(posedge ref_clk);
                    ord_valid <= 1'h1;
                    ord_domain <= hpd_dom_t'(d);
                    ord_later <= hpd_ord_t'(l);
                    ord_earlier <= hpd_ord_t'(e);
                    @(posedge ref_clk);
                    ord_valid <= 1'h0;
                    #1;
                    chk("ord_pass", 64'(ord_pass), {62'h0, 1'h1, p});
                end
            end
        end
    endtask

    task automatic results();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        repeat (16) @(posedge ref_clk);
        rst_b <= 1'h1;
        @(posedge ref_clk);
        #1;
        chk("waitrequest", 64'(avs_waitrequest), 64'h1);
        t_regs();
        t_mem();
        t_io();
        t_cfg();
        t_rmp();
        t_ord();
        results();
    end

    // Whole run needs well under 2000 cycles
    initial begin
        #200000;
        fails++;
        results();
    end
endmodule
`default_nettype wire

// File: bench/hpd_ht_src.sv
// Behavioural chain-side packet source feeding the decoder
`timescale 1ns/1ns
`default_nettype none
module hpd_ht_src (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic send,
    input wire hpd_pkg::hpd_req_t pkt,
    output logic req_valid,
    output hpd_pkg::hpd_req_t req
);
    import hpd_pkg::*;

    // Idle packet fields toggle, so a stale packet never looks fresh
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            req_valid <= 1'h0;
            req <= '0;
        end else begin
            req_valid <= send;
            req <= send ? pkt : ~req;
        end
    end
endmodule
`default_nettype wire

// File: design/hpd_decode.sv
// Inbound address decode, remap and ordering query with Avalon-MM registers
//
// Notes on behaviour
// - Toward HT: posted passes others; responses pass only non-posted; non-posted pass nothing.
// - Toward PCI: posted passes delayed traffic; completions pass only delayed requests.
// - Toward PCI-X: posted passes split traffic; completions pass only split requests.
// - All reachable spaces live in one flat 64-bit map, checked per packet.
// - Memory region: base/limit and prefetch windows accepted when memory decode enabled.
// - Legacy display enable adds memory window 0xA0000 to 0xBFFFF.
// - Sized reads become memory reads, sized writes memory writes; no prefetch.
// - Memory above 4 GB passes unchanged with a dual address cycle.
// - I/O region drops the upper 39 address bits before decoding.
// - I/O decode enable accepts the I/O base/limit window.
// - Legacy ISA enable refuses top 768 bytes of each 1 KB below 64 KB.
// - Legacy display enable accepts low-64K I/O with low bits 3B0-3BB, 3C0-3DF.
// - I/O reads/writes pass low 25 bits; upper bits driven zero.
// - Config region: address bit 24 selects Type 0 or Type 1.
// - Type 0 accepted to internal registers when device equals base unit identifier.
// - Type 1 accepted when bus lies between secondary and subordinate inclusive.
// - Bus equal to secondary becomes Type 0 with IDSEL at device plus 16.
// - Higher buses go out as Type 1 with bits 23:2 kept; no special cycles.
// - Interrupt region accepts only broadcast end-of-interrupt, sent to interrupt controller.
// - One upstream remap window translates addresses and may force isochronous.
// - Remap applies only to PCI-X traffic, which is always forwarded; other forwarded packets keep their address.
// - Downstream sized requests matching nothing are forwarded down the chain.
`timescale 1ns/1ns
`default_nettype none
module hpd_decode (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic req_valid,
    input wire hpd_pkg::hpd_req_t req,
    output logic res_valid,
    output hpd_pkg::hpd_res_t res,
    input wire logic ord_valid,
    input wire hpd_pkg::hpd_dom_t ord_domain,
    input wire hpd_pkg::hpd_ord_t ord_later,
    input wire hpd_pkg::hpd_ord_t ord_earlier,
    output hpd_pkg::hpd_pass_t ord_pass
);
    import hpd_pkg::*;

    typedef struct packed {
        logic [NREG_RW-1:0][31:0] regs;
        logic wait_r;
        logic [31:0] rdata;
        logic res_valid;
        hpd_res_t res;
        logic [15:0] acc_cnt;
        logic [15:0] fwd_cnt;
    } hpd_state_t;

    hpd_state_t s_q;
    hpd_state_t s_d;

    // Decode intermediates
    logic [31:0] ctrl;
    logic [63:0] a;
    logic [31:0] io_a;
    logic [9:0] io_lo10;
    logic [7:0] bus_n;
    logic [7:0] sec_bus;
    logic [7:0] sub_bus;
    logic [4:0] dev_n;
    logic [63:0] pf_base;
    logic [63:0] pf_limit;
    logic [63:0] rmp_base;
    logic [63:0] rmp_limit;
    logic [63:0] rmp_xlat;
    logic mem_hit;
    logic io_win;
    logic vga_io;
    logic isa_hole;
    logic io_hit;
    logic cfg1_hit;
    logic hit;
    logic [15:0] idsel;
    logic [5:0] idx;

    hpd_order u_order (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .ord_valid(ord_valid),
        .ord_domain(ord_domain),
        .ord_later(ord_later),
        .ord_earlier(ord_earlier),
        .pass_q(ord_pass)
    );

    always_comb begin
        s_d = s_q;
        idx = avs_address[7:2];
        ctrl = s_q.regs[IDX_CTRL];
        a = req.addr;
        sec_bus = s_q.regs[IDX_BUS][7:0];
        sub_bus = s_q.regs[IDX_BUS][BUS_SUB_LSB +: 8];
        pf_base = {s_q.regs[IDX_PF_BASE_HI], s_q.regs[IDX_PF_BASE]};
        pf_limit = {s_q.regs[IDX_PF_LIMIT_HI], s_q.regs[IDX_PF_LIMIT]};
        rmp_base = {s_q.regs[IDX_RMP_BASE_HI], s_q.regs[IDX_RMP_BASE]};
        rmp_limit = {s_q.regs[IDX_RMP_LIMIT_HI], s_q.regs[IDX_RMP_LIMIT]};
        rmp_xlat = {s_q.regs[IDX_RMP_XLAT_HI], s_q.regs[IDX_RMP_XLAT]};

        // Register bus: one wait cycle, then the answer for one cycle
        if (s_q.wait_r && (avs_read || avs_write)) begin
            s_d.wait_r = 1'b0;
            s_d.rdata = '0;
            if (idx < 6'(NREG_RW)) begin
                s_d.rdata = s_q.regs[idx[3:0]];
            end else if (idx == IDX_STATUS) begin
                s_d.rdata = {s_q.fwd_cnt, s_q.acc_cnt};
            end
        end else if (!s_q.wait_r) begin
            s_d.wait_r = 1'b1;
            // Write lands on the edge that sees waitrequest low
            if (avs_write && idx < 6'(NREG_RW)) begin
                for (int b = 0; b < 4; b++) begin
                    if (avs_byteenable[b]) begin
                        s_d.regs[idx[3:0]][b*8 +: 8] = avs_writedata[b*8 +: 8];
                    end
                end
            end
        end

        // One flat 64-bit map, each region checked against its own windows
        mem_hit = a <= MEM_TOP && ctrl[CTRL_MEM_EN] &&
                  ((a >= {32'h0, s_q.regs[IDX_MEM_BASE]} &&
                    a <= {32'h0, s_q.regs[IDX_MEM_LIMIT]}) ||
                   (a >= pf_base && a <= pf_limit));
        mem_hit = mem_hit || (ctrl[CTRL_VGA_EN] && a >= VGA_MEM_LO && a <= VGA_MEM_HI);

        io_a = {7'h0, a[IO_KEEP-1:0]};
        io_lo10 = io_a[9:0];
        io_win = ctrl[CTRL_IO_EN] && io_a >= s_q.regs[IDX_IO_BASE] &&
                 io_a <= s_q.regs[IDX_IO_LIMIT];
        isa_hole = ctrl[CTRL_ISA_EN] && io_a < IO_LEGACY_TOP &&
                   (io_a & ISA_HOLE_MASK) != '0;
        vga_io = ctrl[CTRL_VGA_EN] && io_a < IO_LEGACY_TOP &&
                 ((io_lo10 >= VGA_IO_A_LO && io_lo10 <= VGA_IO_A_HI) ||
                  (io_lo10 >= VGA_IO_B_LO && io_lo10 <= VGA_IO_B_HI));
        // Holes win even over the legacy display windows
        io_hit = (io_win || vga_io) && !isa_hole;

        bus_n = a[BUS_MSB:BUS_LSB];
        dev_n = a[DEV_MSB:DEV_LSB];
        cfg1_hit = bus_n >= sec_bus && bus_n <= sub_bus;
        // Only devices 0..15 have an IDSEL line
        idsel = dev_n[4] ? 16'h0 : (16'h1 << dev_n[3:0]);

        s_d.res_valid = req_valid;
        s_d.res = '0;
        s_d.res.addr = a;
        hit = 1'b0;
        if (req.from_pcix) begin
            // Upstream from PCI-X: toward host, remap window applies
            if (ctrl[CTRL_RMP_EN] && a >= rmp_base && a <= rmp_limit) begin
                s_d.res.addr = a - rmp_base + rmp_xlat;
                s_d.res.isoc = ctrl[CTRL_RMP_ISOC];
            end
        end else if (req.downstream && req.eoi) begin
            if (a >= INT_LO && a <= INT_HI && req.broadcast) begin
                hit = 1'b1;
                s_d.res.target = TGT_INTC;
                s_d.res.cycle = CYC_EOI;
            end
        end else if (req.downstream && req.sized) begin
            if (a <= MEM_TOP) begin
                hit = mem_hit;
                // No prefetching, so both memory windows act alike
                s_d.res.cycle = req.write ? CYC_MEM_WR : CYC_MEM_RD;
                s_d.res.dac = a[63:32] != DAC_LIMIT;
            end else if (a >= IO_LO && a <= IO_HI) begin
                hit = io_hit;
                s_d.res.cycle = req.write ? CYC_IO_WR : CYC_IO_RD;
                s_d.res.addr = {39'h0, a[IO_KEEP-1:0]};
            end else if (a >= CFG_LO && a <= CFG_HI) begin
                if (!a[CFG_TYPE_BIT]) begin
                    hit = dev_n == ctrl[CTRL_BUID_LSB +: 5];
                    s_d.res.target = TGT_CSR;
                    s_d.res.cycle = req.write ? CYC_CFG0_WR : CYC_CFG0_RD;
                end else if (bus_n == sec_bus) begin
                    hit = cfg1_hit;
                    s_d.res.cycle = req.write ? CYC_CFG0_WR : CYC_CFG0_RD;
                    s_d.res.addr = {32'h0, idsel, a[DEV_MSB:2], 2'h0};
                end else begin
                    hit = cfg1_hit;
                    s_d.res.cycle = req.write ? CYC_CFG1_WR : CYC_CFG1_RD;
                    s_d.res.addr = {40'h0, a[BUS_MSB:2], CFG1_TAG};
                end
            end
            if (hit && s_d.res.target == TGT_NONE) begin
                s_d.res.target = TGT_PCIX;
            end
        end

        if (hit) begin
            // Broadcasts are forwarded as well as accepted
            s_d.res.action = req.broadcast ? ACT_BOTH : ACT_ACCEPT;
        end else begin
            // Misses and links-to-link traffic go on unchanged; upstream PCI-X traffic keeps any remapped address
            s_d.res.action = ACT_FWD;
            s_d.res.target = TGT_NONE;
            s_d.res.cycle = CYC_NONE;
            s_d.res.dac = 1'b0;
            if (!req.from_pcix) begin
                s_d.res.addr = a;
            end
        end
        if (req_valid) begin
            if (hit) begin
                s_d.acc_cnt = s_q.acc_cnt + 16'h1;
            end else begin
                s_d.fwd_cnt = s_q.fwd_cnt + 16'h1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            s_q <= '0;
            s_q.wait_r <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign avs_readdata = s_q.rdata;
    assign avs_waitrequest = s_q.wait_r;
    assign res_valid = s_q.res_valid;
    assign res = s_q.res;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    bus_answer_a: assert property (
        $fell(avs_waitrequest) |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    vga_mem_a: assert property (
        req_valid && req.downstream && req.sized && !req.from_pcix && !req.eoi &&
        ctrl[CTRL_VGA_EN] && req.addr >= VGA_MEM_LO && req.addr <= VGA_MEM_HI
        |=> res.action != ACT_FWD && res.target == TGT_PCIX)
        else $error("legacy display memory request not accepted");
    dac_flag_a: assert property (
        res_valid && (res.cycle == CYC_MEM_RD || res.cycle == CYC_MEM_WR)
        |-> res.dac == (res.addr[63:32] != 32'h0) && res.addr == $past(req.addr))
        else $error("memory address changed or dual cycle flag wrong");
    io_upper_zero_a: assert property (
        res_valid && (res.cycle == CYC_IO_RD || res.cycle == CYC_IO_WR)
        |-> res.addr[63:IO_KEEP] == '0)
        else $error("I/O address upper bits not zero");
    idsel_onehot_a: assert property (
        res_valid && res.target == TGT_PCIX && res.cycle == CYC_CFG0_RD
        |-> $onehot0(res.addr[31:IDSEL_BASE]) && res.addr[1:0] == 2'h0)
        else $error("type 0 cycle IDSEL not one-hot");
    cfg1_keep_a: assert property (
        res_valid && (res.cycle == CYC_CFG1_RD || res.cycle == CYC_CFG1_WR)
        |-> res.addr[BUS_MSB:2] == $past(req.addr[BUS_MSB:2]) && res.addr[1:0] == CFG1_TAG)
        else $error("type 1 address bits altered");
    fwd_unchanged_a: assert property (
        req_valid && !req.from_pcix && !req.downstream
        |=> res.action == ACT_FWD && res.addr == $past(req.addr) && !res.isoc)
        else $error("forwarded packet was remapped");
    miss_forward_a: assert property (
        res_valid && res.action == ACT_FWD |-> res.target == TGT_NONE && res.cycle == CYC_NONE)
        else $error("forwarded packet still carries a target");
    eoi_only_a: assert property (
        res_valid && res.target == TGT_INTC |-> res.cycle == CYC_EOI && res.action == ACT_BOTH)
        else $error("interrupt controller got a non-broadcast");
endmodule
`default_nettype wire

// File: design/hpd_order.sv
// Passing table for queued transactions toward HT, PCI and PCI-X
`timescale 1ns/1ns
`default_nettype none
module hpd_order (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic ord_valid,
    input wire hpd_pkg::hpd_dom_t ord_domain,
    input wire hpd_pkg::hpd_ord_t ord_later,
    input wire hpd_pkg::hpd_ord_t ord_earlier,
    output var hpd_pkg::hpd_pass_t pass_q
);
    import hpd_pkg::*;

    hpd_pass_t s_d;
    logic is_req;
    logic is_cpl;

    always_comb begin
        is_req = (ord_earlier == ORD_RD_REQ) || (ord_earlier == ORD_WR_REQ);
        is_cpl = (ord_later == ORD_RD_CPL) || (ord_later == ORD_WR_CPL);
        s_d.valid = ord_valid;
        s_d.pass = 1'b0;
        case (ord_domain)
            // Posted passes all but posted; responses pass only requests
            DOM_HT: begin
                s_d.pass = (ord_later == ORD_POSTED && ord_earlier != ORD_POSTED) ||
                           (is_cpl && is_req);
            end
            DOM_PCI: begin
                s_d.pass = (ord_later == ORD_POSTED && ord_earlier != ORD_POSTED) ||
                           (is_cpl && is_req);
            end
            DOM_PCIX: begin
                s_d.pass = (ord_later == ORD_POSTED && ord_earlier != ORD_POSTED) ||
                           (is_cpl && is_req);
            end
            default: s_d.pass = 1'b0;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            pass_q <= '0;
        end else begin
            pass_q <= s_d;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    posted_blocks_a: assert property (
        ord_valid && ord_earlier == ORD_POSTED |=> !pass_q.pass)
        else $error("something passed a posted write");
    request_stuck_a: assert property (
        ord_valid && (ord_later == ORD_RD_REQ || ord_later == ORD_WR_REQ) |=> !pass_q.pass)
        else $error("a request passed something");
    cpl_over_req_a: assert property (
        ord_valid && ord_domain == DOM_PCIX && ord_later == ORD_RD_CPL &&
        ord_earlier == ORD_WR_REQ |=> pass_q.pass && pass_q.valid)
        else $error("completion failed to pass a split request");
endmodule
`default_nettype wire

// File: design/hpd_pkg.sv
// Shared constants and types for the inbound decode and ordering block
`default_nettype none
package hpd_pkg;
    // Flat 64-bit address map regions, inclusive bounds
    localparam logic [63:0] MEM_TOP = 64'h0000_00fc_ffff_ffff;
    localparam logic [63:0] VGA_MEM_LO = 64'h0000_0000_000a_0000;
    localparam logic [63:0] VGA_MEM_HI = 64'h0000_0000_000b_ffff;
    localparam logic [63:0] INT_LO = 64'h0000_00fd_f800_0000;
    localparam logic [63:0] INT_HI = 64'h0000_00fd_f8ff_ffff;
    localparam logic [63:0] IO_LO = 64'h0000_00fd_fc00_0000;
    localparam logic [63:0] IO_HI = 64'h0000_00fd_fdff_ffff;
    localparam logic [63:0] CFG_LO = 64'h0000_00fd_fe00_0000;
    localparam logic [63:0] CFG_HI = 64'h0000_00fd_ffff_ffff;
    localparam logic [31:0] DAC_LIMIT = 32'h0000_0000;
    // I/O: top 39 bits stripped, 25 kept
    localparam int IO_KEEP = 25;
    localparam logic [31:0] IO_LEGACY_TOP = 32'h0001_0000;
    localparam logic [31:0] ISA_HOLE_MASK = 32'h0000_0300;
    localparam logic [9:0] VGA_IO_A_LO = 10'h3b0;
    localparam logic [9:0] VGA_IO_A_HI = 10'h3bb;
    localparam logic [9:0] VGA_IO_B_LO = 10'h3c0;
    localparam logic [9:0] VGA_IO_B_HI = 10'h3df;
    // Configuration address fields
    localparam int CFG_TYPE_BIT = 24;
    localparam int BUS_MSB = 23;
    localparam int BUS_LSB = 16;
    localparam int DEV_MSB = 15;
    localparam int DEV_LSB = 11;
    localparam int IDSEL_BASE = 16;
    localparam logic [1:0] CFG1_TAG = 2'h1;
    // Register indices; byte address is four times the index
    localparam int NREG_RW = 16;
    localparam logic [5:0] IDX_CTRL = 6'h00;
    localparam logic [5:0] IDX_BUS = 6'h01;
    localparam logic [5:0] IDX_MEM_BASE = 6'h02;
    localparam logic [5:0] IDX_MEM_LIMIT = 6'h03;
    localparam logic [5:0] IDX_PF_BASE = 6'h04;
    localparam logic [5:0] IDX_PF_BASE_HI = 6'h05;
    localparam logic [5:0] IDX_PF_LIMIT = 6'h06;
    localparam logic [5:0] IDX_PF_LIMIT_HI = 6'h07;
    localparam logic [5:0] IDX_IO_BASE = 6'h08;
    localparam logic [5:0] IDX_IO_LIMIT = 6'h09;
    localparam logic [5:0] IDX_RMP_BASE = 6'h0a;
    localparam logic [5:0] IDX_RMP_BASE_HI = 6'h0b;
    localparam logic [5:0] IDX_RMP_LIMIT = 6'h0c;
    localparam logic [5:0] IDX_RMP_LIMIT_HI = 6'h0d;
    localparam logic [5:0] IDX_RMP_XLAT = 6'h0e;
    localparam logic [5:0] IDX_RMP_XLAT_HI = 6'h0f;
    localparam logic [5:0] IDX_STATUS = 6'h10;
    // Control and bus register bits
    localparam int CTRL_MEM_EN = 0;
    localparam int CTRL_IO_EN = 1;
    localparam int CTRL_VGA_EN = 2;
    localparam int CTRL_ISA_EN = 3;
    localparam int CTRL_RMP_EN = 4;
    localparam int CTRL_RMP_ISOC = 5;
    localparam int CTRL_BUID_LSB = 8;
    localparam int BUS_SUB_LSB = 8;

    typedef enum logic [1:0] {ACT_FWD = 2'h0, ACT_ACCEPT = 2'h1, ACT_BOTH = 2'h2} hpd_act_t;
    typedef enum logic [1:0] {TGT_NONE = 2'h0, TGT_PCIX = 2'h1, TGT_CSR = 2'h2,
                              TGT_INTC = 2'h3} hpd_tgt_t;
    typedef enum logic [3:0] {
        CYC_NONE = 4'h0, CYC_MEM_RD = 4'h1, CYC_MEM_WR = 4'h2, CYC_IO_RD = 4'h3,
        CYC_IO_WR = 4'h4, CYC_CFG0_RD = 4'h5, CYC_CFG0_WR = 4'h6, CYC_CFG1_RD = 4'h7,
        CYC_CFG1_WR = 4'h8, CYC_EOI = 4'h9
    } hpd_cyc_t;
    typedef enum logic [1:0] {DOM_HT = 2'h0, DOM_PCI = 2'h1, DOM_PCIX = 2'h2} hpd_dom_t;
    // Request/completion classes; on HT reads and writes share one class each
    typedef enum logic [2:0] {
        ORD_POSTED = 3'h0, ORD_RD_REQ = 3'h1, ORD_WR_REQ = 3'h2, ORD_RD_CPL = 3'h3,
        ORD_WR_CPL = 3'h4
    } hpd_ord_t;

    typedef struct packed {
        logic [63:0] addr;
        logic write;
        logic sized;
        logic eoi;
        logic broadcast;
        logic downstream;
        logic from_pcix;
    } hpd_req_t;

    typedef struct packed {
        hpd_act_t action;
        hpd_tgt_t target;
        hpd_cyc_t cycle;
        logic [63:0] addr;
        logic dac;
        logic isoc;
    } hpd_res_t;

    typedef struct packed {
        logic valid;
        logic pass;
    } hpd_pass_t;
endpackage
`default_nettype wire
